// *** src/fpc_pkg.sv ***
// Shared constants and types for the flash pin control block
package fpc_pkg;

  // Bus widths
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int STAT_W = 8;

  // Read configuration register layout and reset value
  localparam int RCR_WAIT_POL_POS = 10;
  localparam int RCR_SYNC_POS = 15;
  localparam logic [DATA_W-1:0] RCR_RST = 16'h0000;

  // Status register value after any reset
  localparam logic [STAT_W-1:0] STATUS_RST = 8'h80;

  // Upper half of a status read
  localparam logic [DATA_W-STAT_W-1:0] STATUS_PAD = 8'h00;

  // Source of read data
  typedef enum logic [1:0] {
    SRC_ARRAY,
    SRC_STATUS,
    SRC_PROT,
    SRC_CONFIG
  } fpc_src_t;

  // Unlock and array-altering operations that the gate judges
  typedef enum logic [1:0] {
    OP_UNLOCK,
    OP_PROGRAM,
    OP_ERASE
  } fpc_op_t;

  // Bus phase seen on the control pins
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_READ,
    PH_WRITE,
    PH_HALT
  } fpc_phase_t;

  // One captured write cycle
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fpc_wr_t;

  // Operation request from the command engine
  typedef struct packed {
    logic valid;
    fpc_op_t op;
    logic locked;
    logic lockdown;
  } fpc_req_t;

  // Verdict on a request
  typedef struct packed {
    logic grant;
    logic refuse;
  } fpc_ans_t;

endpackage : fpc_pkg

// *** src/fpc_cmd_gate.sv ***
// Protection gate that grants or refuses array-altering operations
`timescale 1ns/1ps

module fpc_cmd_gate (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Request and protection levels
  input wire fpc_pkg::fpc_req_t req_i,
  input wire logic write_protect_low_i,
  input wire logic vpp_lockout_i,
  input wire logic halt_i,
  // Verdict, one cycle after the request
  output fpc_pkg::fpc_ans_t ans_o
);

  logic is_unlock;
  logic alters;
  logic refuse;
  fpc_pkg::fpc_ans_t nxt_ans;

  // Decode; protect pin is judged as the request executes
  assign is_unlock = (req_i.op == fpc_pkg::OP_UNLOCK);
  assign alters = !is_unlock;
  assign refuse = halt_i
    | (alters & vpp_lockout_i)
    | (alters & req_i.locked)
    | (is_unlock & req_i.lockdown & !write_protect_low_i);
  assign nxt_ans.grant = req_i.valid & !refuse;
  assign nxt_ans.refuse = req_i.valid & refuse;

  // Registered verdict
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ans_o <= '0;
    end else begin
      ans_o <= nxt_ans;
    end
  end

  AST_HALT_REFUSES:
  assert property (@(posedge clk_sys_i) disable iff (rst_i)
    req_i.valid && halt_i |=> ans_o.refuse && !ans_o.grant)
    else $error("request granted during reset");

  AST_VPP_BLOCKS:
  assert property (@(posedge clk_sys_i) disable iff (rst_i)
    req_i.valid && req_i.op != fpc_pkg::OP_UNLOCK && vpp_lockout_i |=> !ans_o.grant)
    else $error("alteration granted under program supply lockout");

  AST_LOCKDOWN_HOLDS:
  assert property (@(posedge clk_sys_i) disable iff (rst_i)
    req_i.valid && is_unlock && req_i.lockdown && !write_protect_low_i |=> ans_o.refuse)
    else $error("lock-down block unlocked with protect low");

  AST_WP_HIGH_OVERRIDES:
  assert property (@(posedge clk_sys_i) disable iff (rst_i)
    req_i.valid && is_unlock && write_protect_low_i && !halt_i |=> ans_o.grant)
    else $error("unlock refused with protect high");

endmodule : fpc_cmd_gate

// *** src/fpc_pin_ctrl.sv ***
// Pin-level control of the flash host interface: reset, writes, data and wait pins
`timescale 1ns/1ps

module fpc_pin_ctrl #(
  parameter int ADDR_W = fpc_pkg::ADDR_W,
  parameter int DATA_W = fpc_pkg::DATA_W
) (
  // Clock and system reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Flash control pins
  input wire logic pin_rst_low_i,
  input wire logic die_select_low_i,
  input wire logic die_output_enable_low_i,
  input wire logic write_strobe_low_i,
  input wire logic write_protect_low_i,
  input wire logic vpp_lockout_i,
  // Address and data pins
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] dq_i,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  // Wait pin
  output logic wait_o,
  output logic wait_oe_o,
  // Read sources from the core
  input wire logic [DATA_W-1:0] arr_data_i,
  input wire logic [DATA_W-1:0] prot_data_i,
  input wire logic burst_data_valid_i,
  input wire logic src_set_i,
  input wire fpc_pkg::fpc_src_t src_sel_i,
  // Register loads from the command engine
  input wire logic cfg_load_i,
  input wire logic [DATA_W-1:0] cfg_data_i,
  input wire logic status_load_i,
  input wire logic [fpc_pkg::STAT_W-1:0] status_data_i,
  // Captured write cycles
  output fpc_pkg::fpc_wr_t wr_o,
  output logic wr_valid_o,
  // Automation control
  output logic auto_reset_o,
  output logic sync_mode_o,
  // Protection gate
  input wire fpc_pkg::fpc_req_t gate_req_i,
  output fpc_pkg::fpc_ans_t gate_ans_o
);

  // Widths are fixed by the shared structs
  if (ADDR_W != fpc_pkg::ADDR_W || DATA_W != fpc_pkg::DATA_W) begin : g_bad_width
    $error("fpc_pin_ctrl: widths must match the package");
  end

  // State
  fpc_pkg::fpc_phase_t phase_ff;
  fpc_pkg::fpc_phase_t nxt_phase;
  fpc_pkg::fpc_src_t src_ff;
  logic [DATA_W-1:0] rcr_ff;
  logic [fpc_pkg::STAT_W-1:0] status_ff;
  logic [ADDR_W-1:0] addr_q_ff;
  logic [DATA_W-1:0] dq_q_ff;

  // Decoded pin conditions
  logic halt;
  logic sel;
  logic rd_cyc;
  logic wr_cyc;
  logic wr_end;
  logic wait_pol;
  logic sync_mode;
  logic wait_busy;
  logic [DATA_W-1:0] rd_mux;

  // Next values of pin outputs
  logic nxt_dq_oe;
  logic nxt_wait_oe;
  logic nxt_wait;
  logic nxt_wr_valid;

  // Flash reset pin holds modes, status, pin enables and automation in reset
  assign halt = !pin_rst_low_i;
  assign sel = !die_select_low_i;
  assign rd_cyc = sel & !die_output_enable_low_i & write_strobe_low_i;
  assign wr_cyc = sel & write_strobe_low_i == 1'b0 & die_output_enable_low_i;

  // Phase of the pins, halt wins over everything
  always_comb begin
    if (halt) begin
      nxt_phase = fpc_pkg::PH_HALT;
    end else if (wr_cyc) begin
      nxt_phase = fpc_pkg::PH_WRITE;
    end else if (rd_cyc) begin
      nxt_phase = fpc_pkg::PH_READ;
    end else begin
      nxt_phase = fpc_pkg::PH_IDLE;
    end
  end

  // First rising edge of strobe or select ends the write
  assign wr_end = (phase_ff == fpc_pkg::PH_WRITE) & (write_strobe_low_i | die_select_low_i);
  assign nxt_wr_valid = wr_end & !halt;

  // Configuration fields
  assign wait_pol = rcr_ff[fpc_pkg::RCR_WAIT_POL_POS];
  assign sync_mode = rcr_ff[fpc_pkg::RCR_SYNC_POS];

  // Read data source selection
  always_comb begin
    unique case (src_ff)
      fpc_pkg::SRC_ARRAY: rd_mux = arr_data_i;
      fpc_pkg::SRC_STATUS: rd_mux = {fpc_pkg::STATUS_PAD, status_ff};
      fpc_pkg::SRC_PROT: rd_mux = prot_data_i;
      fpc_pkg::SRC_CONFIG: rd_mux = rcr_ff;
    endcase
  end

  // Data buffer only in a read; wait buffer whenever select and enable are low outside reset
  assign nxt_dq_oe = (nxt_phase == fpc_pkg::PH_READ);
  assign nxt_wait_oe = sel & !die_output_enable_low_i & !halt;

  // Wait is busy only in a synchronous read lacking data
  assign wait_busy = (nxt_phase == fpc_pkg::PH_READ) & sync_mode & !burst_data_valid_i;
  assign nxt_wait = wait_busy ? wait_pol : !wait_pol;

  // Phase register
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      phase_ff <= fpc_pkg::PH_HALT;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  // Address and data held one cycle so the value at the edge is kept
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      addr_q_ff <= '0;
      dq_q_ff <= '0;
    end else begin
      addr_q_ff <= addr_i;
      dq_q_ff <= dq_i;
    end
  end

  // Write capture, latched until the next cycle ends
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wr_o <= '0;
      wr_valid_o <= 1'b0;
    end else begin
      wr_valid_o <= nxt_wr_valid;
      if (nxt_wr_valid) begin
        wr_o.addr <= addr_q_ff;
        wr_o.data <= dq_q_ff;
      end
    end
  end

  // Read mode; any reset returns to asynchronous array reads
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || halt) begin
      src_ff <= fpc_pkg::SRC_ARRAY;
      rcr_ff <= fpc_pkg::RCR_RST;
    end else begin
      if (src_set_i) begin
        src_ff <= src_sel_i;
      end
      if (cfg_load_i) begin
        rcr_ff <= cfg_data_i;
      end
    end
  end

  // Status register
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || halt) begin
      status_ff <= fpc_pkg::STATUS_RST;
    end else if (status_load_i) begin
      status_ff <= status_data_i;
    end
  end

  // Pin drivers, registered for clean outputs
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      dq_o <= '0;
      dq_oe_o <= 1'b0;
      wait_o <= 1'b1;
      wait_oe_o <= 1'b0;
    end else begin
      dq_o <= rd_mux;
      dq_oe_o <= nxt_dq_oe;
      wait_o <= nxt_wait;
      wait_oe_o <= nxt_wait_oe;
    end
  end

  // Automation held in reset while the pin is low
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      auto_reset_o <= 1'b1;
      sync_mode_o <= 1'b0;
    end else begin
      auto_reset_o <= halt;
      sync_mode_o <= sync_mode && !halt;
    end
  end

  // Protection decisions live in their own small block
  fpc_cmd_gate u_gate (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .req_i(gate_req_i),
    .write_protect_low_i(write_protect_low_i),
    .vpp_lockout_i(vpp_lockout_i),
    .halt_i(halt),
    .ans_o(gate_ans_o)
  );

  AST_DQ_FLOAT:
  assert property (@(posedge clk_sys_i) disable iff (rst_i)
    die_select_low_i || die_output_enable_low_i |=> !dq_oe_o)
    else $error("data bus driven while deselected");

  AST_WAIT_FLOAT:
  assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !die_select_low_i && !die_output_enable_low_i && pin_rst_low_i |=> wait_oe_o)
    else $error("wait not driven while selected and enabled");

  AST_DQ_READ:
  assert property (@(posedge clk_sys_i) disable iff (rst_i)
    rd_cyc && pin_rst_low_i |=> dq_oe_o && dq_o == $past(rd_mux))
    else $error("read data not driven");

  AST_NO_WRITE_IN_RESET:
  assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !pin_rst_low_i |=> !wr_valid_o && auto_reset_o)
    else $error("write accepted during flash reset");

  AST_CAPTURE:
  assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_end && pin_rst_low_i |=> wr_valid_o && wr_o.data == $past(dq_i, 2) && wr_o.addr == $past(addr_i, 2))
    else $error("write capture wrong");

  AST_RESET_EXIT:
  assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !pin_rst_low_i ##1 pin_rst_low_i |-> src_ff == fpc_pkg::SRC_ARRAY && !sync_mode && status_ff == fpc_pkg::STATUS_RST)
    else $error("reset exit not in asynchronous array mode");

  AST_WAIT_ASYNC:
  assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !sync_mode || wr_cyc |=> wait_o == !$past(wait_pol))
    else $error("wait asserted outside synchronous read");

  AST_WAIT_BURST:
  assert property (@(posedge clk_sys_i) disable iff (rst_i)
    rd_cyc && pin_rst_low_i && sync_mode && !burst_data_valid_i |=> wait_o == $past(wait_pol))
    else $error("wait not asserted for invalid burst data");

  AST_BURST_VALID:
  assert property (@(posedge clk_sys_i) disable iff (rst_i)
    rd_cyc && pin_rst_low_i && sync_mode && burst_data_valid_i |=> wait_o == !$past(wait_pol))
    else $error("wait asserted while burst data valid");

  AST_WAIT_HIZ:
  assert property (@(posedge clk_sys_i) disable iff (rst_i)
    die_select_low_i || die_output_enable_low_i |=> !wait_oe_o)
    else $error("wait driven while deselected or disabled");

  AST_HALT_FLOAT:
  assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !pin_rst_low_i |=> !dq_oe_o && !wait_oe_o)
    else $error("pins driven during flash reset");

  AST_HALT_DEFAULTS:
  assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !pin_rst_low_i |=> status_ff == fpc_pkg::STATUS_RST && rcr_ff == fpc_pkg::RCR_RST
      && src_ff == fpc_pkg::SRC_ARRAY)
    else $error("flash reset did not restore defaults");

  AST_WR_ONE_PULSE:
  assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_valid_o |=> !wr_valid_o)
    else $error("write capture pulse longer than one cycle");

endmodule : fpc_pin_ctrl

// *** bench/fpc_host_model.sv ***
// Host model driving the flash control, address and data pins
`timescale 1ns/1ps

module fpc_host_model (
  // Clock
  input wire logic clk_sys_i,
  // Pins toward the device
  output logic sel_low_o,
  output logic oe_low_o,
  output logic we_low_o,
  output logic [fpc_pkg::ADDR_W-1:0] addr_o,
  output logic [fpc_pkg::DATA_W-1:0] dq_o
);
  // Idle bus: deselected, strobes high
  initial begin
    sel_low_o = 1'b1;
    oe_low_o = 1'b1;
    we_low_o = 1'b1;
    addr_o = 24'h000000;
    dq_o = 16'hffff;
  end

  // Control levels change just after an edge
  task automatic pins(input logic s, input logic o, input logic w);
    @(posedge clk_sys_i);
    sel_low_o <= s;
    oe_low_o <= o;
    we_low_o <= w;
  endtask : pins

  // Strobe or select rises first; whichever it is ends the cycle
  task automatic wr_cycle(input logic [fpc_pkg::ADDR_W-1:0] a, input logic [fpc_pkg::DATA_W-1:0] d,
    input logic sel_first);
    pins(1'b0, 1'b1, 1'b0);
    addr_o <= a;
    dq_o <= d;
    repeat (2) @(posedge clk_sys_i);
    if (sel_first) begin
      sel_low_o <= 1'b1;
    end else begin
      we_low_o <= 1'b1;
    end
    @(posedge clk_sys_i);
    sel_low_o <= 1'b1;
    we_low_o <= 1'b1;
    // Released lines show no stale value
    addr_o <= ~a;
    dq_o <= ~d;
  endtask : wr_cycle
endmodule : fpc_host_model

// *** bench/fpc_pin_ctrl_bench.sv ***
// Self-checking bench for the flash pin control block
`timescale 1ns/1ps

module fpc_pin_ctrl_bench;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic pin_rst_low = 1'b1, wp_low = 1'b0, vpp_lock = 1'b0, burst_ok = 1'b0, src_set = 1'b0, cfg_load = 1'b0;
  logic [15:0] arr_data = 16'h0000, cfg_data = 16'h0000;
  logic status_load = 1'b0;
  logic [7:0] status_data = 8'h00;
  fpc_pkg::fpc_src_t src_sel = fpc_pkg::SRC_ARRAY;
  fpc_pkg::fpc_req_t req = '0;
  logic sel_low, oe_low, we_low, dq_oe, wait_lvl, wait_oe, wr_valid, auto_rst, sync_mode;
  logic [23:0] addr;
  logic [15:0] host_dq, dq_out, dq_bus;
  fpc_pkg::fpc_wr_t wr;
  fpc_pkg::fpc_ans_t ans;
  int fail_count = 0;
  int num_checks = 0;

  // Clock and shared data wire
  always #10 clk_sys_i = ~clk_sys_i;
  assign dq_bus = dq_oe ? dq_out : host_dq;

  fpc_host_model fpc_host_model_inst (.clk_sys_i(clk_sys_i), .sel_low_o(sel_low), .oe_low_o(oe_low),
    .we_low_o(we_low), .addr_o(addr), .dq_o(host_dq));

  // Protection data is a fixed pattern
  fpc_pin_ctrl fpc_pin_ctrl_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .pin_rst_low_i(pin_rst_low),
    .die_select_low_i(sel_low), .die_output_enable_low_i(oe_low), .write_strobe_low_i(we_low),
    .write_protect_low_i(wp_low), .vpp_lockout_i(vpp_lock), .addr_i(addr), .dq_i(dq_bus), .dq_o(dq_out),
    .dq_oe_o(dq_oe), .wait_o(wait_lvl), .wait_oe_o(wait_oe), .arr_data_i(arr_data), .prot_data_i(16'h1234),
    .burst_data_valid_i(burst_ok), .src_set_i(src_set), .src_sel_i(src_sel), .cfg_load_i(cfg_load),
    .cfg_data_i(cfg_data), .status_load_i(status_load), .status_data_i(status_data), .wr_o(wr),
    .wr_valid_o(wr_valid),
    .auto_reset_o(auto_rst), .sync_mode_o(sync_mode), .gate_req_i(req), .gate_ans_o(ans));

  task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic step();
    @(posedge clk_sys_i);
    #1;
  endtask : step

  // Counts capture pulses over a short window; a long pulse counts twice
  task automatic wr_pulses(output int n);
    n = 0;
    repeat (4) begin
      #1 if (wr_valid === 1'b1) n++;
      @(posedge clk_sys_i);
    end
  endtask : wr_pulses

  task automatic gate(input fpc_pkg::fpc_op_t op, input logic ld, input logic lk, input logic [1:0] exp);
    @(posedge clk_sys_i);
    req <= '{valid: 1'b1, op: op, locked: lk, lockdown: ld};
    @(posedge clk_sys_i);
    req <= '0;
    #1 chk("gate verdict", 40'(ans), 40'(exp));
  endtask : gate

  task automatic load_cfg(input logic [15:0] v);
    @(posedge clk_sys_i);
    cfg_load <= 1'b1;
    cfg_data <= v;
    @(posedge clk_sys_i);
    cfg_load <= 1'b0;
  endtask : load_cfg

  // Returns once the new source shows on the data pins
  task automatic set_src(input fpc_pkg::fpc_src_t s);
    @(posedge clk_sys_i);
    src_set <= 1'b1;
    src_sel <= s;
    @(posedge clk_sys_i);
    src_set <= 1'b0;
    step();
  endtask : set_src

  task automatic t_write();
    int n;
    for (int i = 0; i < 2; i++) begin
      fpc_host_model_inst.wr_cycle(i ? 24'hfffffe : 24'h00abcd, i ? 16'ha5a5 : 16'h5a5a, i == 1);
      wr_pulses(n);
      chk("capture pulses", 40'(n), 40'd1);
      chk("captured cycle", 40'(wr), i ? 40'hfffffea5a5 : 40'h00abcd5a5a);
    end
  endtask : t_write

  task automatic t_read();
    fpc_host_model_inst.pins(1'b0, 1'b0, 1'b1);
    arr_data <= 16'hc3a5;
    step();
    chk("async read", 40'({dq_oe, wait_oe, wait_lvl, dq_out}), 40'({3'b111, 16'hc3a5}));
    set_src(fpc_pkg::SRC_STATUS);
    chk("status read", 40'(dq_out), 40'h0080);
    @(posedge clk_sys_i);
    status_load <= 1'b1;
    status_data <= 8'h3c;
    @(posedge clk_sys_i);
    status_load <= 1'b0;
    step();
    chk("status loaded", 40'(dq_out), 40'h003c);
    set_src(fpc_pkg::SRC_PROT);
    chk("protection read", 40'(dq_out), 40'h1234);
    load_cfg(16'h0400);
    set_src(fpc_pkg::SRC_CONFIG);
    chk("config read", 40'({wait_lvl, dq_out}), 40'({1'b0, 16'h0400}));
    fpc_host_model_inst.pins(1'b1, 1'b0, 1'b1);
    step();
    chk("deselect float", 40'({dq_oe, wait_oe}), 40'h0);
    fpc_host_model_inst.pins(1'b0, 1'b1, 1'b1);
    step();
    chk("output disable float", 40'({dq_oe, wait_oe}), 40'h0);
  endtask : t_read

  // Polarity high first, then low, with data valid toggled
  task automatic t_burst();
    load_cfg(16'h8400);
    fpc_host_model_inst.pins(1'b0, 1'b0, 1'b1);
    step();
    chk("burst wait invalid", 40'({sync_mode, wait_oe, wait_lvl}), 40'h7);
    @(posedge clk_sys_i);
    burst_ok <= 1'b1;
    step();
    chk("burst wait valid", 40'(wait_lvl), 40'h0);
    load_cfg(16'h8000);
    burst_ok <= 1'b0;
    step();
    chk("burst wait low polarity", 40'(wait_lvl), 40'h0);
    fpc_host_model_inst.pins(1'b1, 1'b1, 1'b1);
  endtask : t_burst

  task automatic t_gate();
    gate(fpc_pkg::OP_UNLOCK, 1'b1, 1'b0, 2'b01);
    @(posedge clk_sys_i);
    wp_low <= 1'b1;
    gate(fpc_pkg::OP_UNLOCK, 1'b1, 1'b0, 2'b10);
    gate(fpc_pkg::OP_PROGRAM, 1'b0, 1'b1, 2'b01);
    @(posedge clk_sys_i);
    vpp_lock <= 1'b1;
    gate(fpc_pkg::OP_PROGRAM, 1'b0, 1'b0, 2'b01);
    gate(fpc_pkg::OP_ERASE, 1'b0, 1'b0, 2'b01);
    @(posedge clk_sys_i);
    vpp_lock <= 1'b0;
    gate(fpc_pkg::OP_ERASE, 1'b1, 1'b0, 2'b10);
  endtask : t_gate

  // Config and read source must come back to their defaults
  task automatic t_pin_reset();
    int n;
    load_cfg(16'h8400);
    pin_rst_low <= 1'b0;
    fpc_host_model_inst.wr_cycle(24'h000111, 16'h0040, 1'b0);
    wr_pulses(n);
    chk("write in reset", 40'(n), 40'd0);
    chk("automation reset", 40'(auto_rst), 40'h1);
    gate(fpc_pkg::OP_ERASE, 1'b0, 1'b0, 2'b01);
    fpc_host_model_inst.pins(1'b0, 1'b0, 1'b1);
    step();
    chk("read in reset", 40'({dq_oe, wait_oe}), 40'h0);
    @(posedge clk_sys_i);
    pin_rst_low <= 1'b1;
    step();
    chk("reset exit", 40'({auto_rst, sync_mode, dq_oe, wait_lvl, dq_out}), 40'({4'b0011, 16'hc3a5}));
    set_src(fpc_pkg::SRC_STATUS);
    chk("status after reset", 40'(dq_out), 40'h0080);
    set_src(fpc_pkg::SRC_CONFIG);
    chk("config after reset", 40'(dq_out), 40'h0000);
  endtask : t_pin_reset

  task automatic results();
    if (fail_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  // Main sequence
  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    step();
    chk("idle after reset", 40'({auto_rst, sync_mode, dq_oe, wait_oe}), 40'h0);
    t_write();
    t_read();
    t_burst();
    t_gate();
    t_pin_reset();
    results();
  end

  // Watchdog well beyond the hundred or so cycles needed
  initial begin
    repeat (2000) @(posedge clk_sys_i);
    fail_count++;
    results();
  end
endmodule : fpc_pin_ctrl_bench
